// ==== src/dioh_handler.sv ====
// dedicated parallel i/o handler: report bus, external jog, gripper mirrors, faults, zones.
// assumes all pins synchronous to CORE_CLK_IN; software values arrive over apb.
`timescale 1ns/1ns
// Notes on behaviour
// - level inputs keep their function active exactly while asserted
// - edge inputs act only on a low-to-high transition
// - state set by an edge input holds after the input drops
// - line-number request edge puts the line number on the value bus
// - line-number indicator high while the bus carries the line number
// - override request edge puts the speed override on the value bus
// - override indicator high while the bus carries the override
// - fault-code request edge puts error number out with its indicator
// - jog permit edge enables external jog, reported on permit output
// - two-bit jog style taken as level and reported back
// - per-axis plus and minus jog requests move only while held
// - three gripper output mirrors copy general output groups
// - three gripper input mirrors copy gripper input groups
// - gripper fault outputs follow level fault inputs per mechanism
// - air pressure fault outputs follow their inputs
// - wear warning asserted once parts reach replacement time
// - eight zone outputs, each high while robot is inside its zone; the code also gates each by its software zone enable bit
// - value bus configured by in start, in end, out start, out end; only the out start..end span is used, as a width mask
// - value bus carries the value of the active report request
module dioh_handler #(
  parameter int NAXES  = dioh_pkg::DIOH_NAXES,
  parameter int NMECH  = dioh_pkg::DIOH_NMECH,
  parameter int NZONES = dioh_pkg::DIOH_NZONES
) (
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 RESET_IN,
  input  wire logic                 PSEL_IN,
  input  wire logic                 PENABLE_IN,
  input  wire logic                 PWRITE_IN,
  input  wire logic [11:0]          PADDR_IN,
  input  wire logic [31:0]          PWDATA_IN,
  output logic      [31:0]          PRDATA_OUT,
  output logic                      PREADY_OUT,
  output logic                      PSLVERR_OUT,
  input  wire logic                 LINE_NUMBER_REPORT_REQUEST_IN,
  input  wire logic                 SPEED_SCALE_REPORT_REQUEST_IN,
  input  wire logic                 FAULT_CODE_REPORT_REQUEST_IN,
  input  wire logic                 MANUAL_MOVE_PERMIT_IN,
  input  wire logic [1:0]           MANUAL_MOVE_STYLE_IN,
  input  wire dioh_pkg::dioh_jog_s  JOG_REQ_IN,
  input  wire logic [NMECH*8-1:0]   GRIPPER_INPUTS_IN,
  input  wire logic [NMECH-1:0]     GRIPPER_FAULT_IN,
  input  wire logic [NMECH-1:0]     AIR_PRESSURE_FAULT_IN,
  input  wire logic [NZONES-1:0]    ROBOT_IN_ZONE_IN,
  output logic      [31:0]          NUMERIC_VALUE_BUS_OUT,
  output logic                      LINE_NUMBER_REPORT_OUT,
  output logic                      SPEED_SCALE_REPORT_OUT,
  output logic                      FAULT_CODE_REPORT_OUT,
  output logic                      MANUAL_MOVE_PERMIT_OUT,
  output logic      [1:0]           MANUAL_MOVE_STYLE_OUT,
  output dioh_pkg::dioh_jog_s       JOG_MOVE_OUT,
  output logic      [NMECH*8-1:0]   GRIPPER_OUTPUT_MIRROR_OUT,
  output logic      [NMECH*8-1:0]   GRIPPER_INPUT_MIRROR_OUT,
  output logic      [NMECH-1:0]     GRIPPER_FAULT_OUT,
  output logic      [NMECH-1:0]     AIR_PRESSURE_FAULT_OUT,
  output logic      [NMECH-1:0]     PARTS_WEAR_WARNING_OUT,
  output logic      [NZONES-1:0]    ZONE_OCCUPANCY_OUT
);
  import dioh_pkg::*;

  logic [31:0]        line_reg;
  logic [31:0]        ovrd_reg;
  logic [31:0]        errn_reg;
  logic [31:0]        gpo_reg;
  logic [NMECH-1:0]   wear_reg;
  logic [NZONES-1:0]  zone_en_reg;
  logic [31:0]        buscfg_reg;
  logic [2:0]         req_prev_reg;
  logic               permit_prev_reg;
  logic               permit_reg;
  dioh_src_e          src_reg;
  dioh_src_e          src_next;

  // apb decode; single-cycle access, pready registered high for the access cycle after setup
  wire        acc      = PSEL_IN & PENABLE_IN;
  wire        wr       = acc & PWRITE_IN;
  wire        hit_ctrl = PADDR_IN == DIOH_CTRL_OFF;
  wire        hit_line = PADDR_IN == DIOH_LINE_OFF;
  wire        hit_ovrd = PADDR_IN == DIOH_OVRD_OFF;
  wire        hit_errn = PADDR_IN == DIOH_ERRN_OFF;
  wire        hit_gpo  = PADDR_IN == DIOH_GPO_OFF;
  wire        hit_wear = PADDR_IN == DIOH_WEAR_OFF;
  wire        hit_zone = PADDR_IN == DIOH_ZONE_OFF;
  wire        hit_bcfg = PADDR_IN == DIOH_BUSCFG_OFF;
  wire        hit_stat = PADDR_IN == DIOH_STAT_OFF;
  wire        mapped   = hit_ctrl | hit_line | hit_ovrd | hit_errn | hit_gpo | hit_wear
                         | hit_zone | hit_bcfg | hit_stat;
  wire        jog_clr  = wr & hit_ctrl & PWDATA_IN[DIOH_CTRL_JOGCLR];
  wire [31:0] stat_val = {24'h000000, permit_reg, MANUAL_MOVE_STYLE_IN, 3'h0, src_reg};
  wire [31:0] rd_val   = hit_line ? line_reg :
                         hit_ovrd ? ovrd_reg :
                         hit_errn ? errn_reg :
                         hit_gpo  ? gpo_reg :
                         hit_wear ? {{(32-NMECH){1'b0}}, wear_reg} :
                         hit_zone ? {{(32-NZONES){1'b0}}, zone_en_reg} :
                         hit_bcfg ? buscfg_reg :
                         hit_stat ? stat_val : DIOH_ZERO;

  // rising edges of the edge-qualified request pins
  wire [2:0] req_now  = {FAULT_CODE_REPORT_REQUEST_IN, SPEED_SCALE_REPORT_REQUEST_IN,
                         LINE_NUMBER_REPORT_REQUEST_IN};
  wire [2:0] req_rise = req_now & ~req_prev_reg;
  wire       permit_rise = MANUAL_MOVE_PERMIT_IN & ~permit_prev_reg;

  // newest request wins; lowest index decides a tie, so one source only
  always_comb begin
    src_next = src_reg;
    if (req_rise[0]) begin
      src_next = DIOH_SRC_LINE;
    end else if (req_rise[1]) begin
      src_next = DIOH_SRC_OVRD;
    end else if (req_rise[2]) begin
      src_next = DIOH_SRC_ERRN;
    end
  end

  // output width narrowed to the configured out start..end span
  wire [7:0]  out_lo   = buscfg_reg[23:16];
  wire [7:0]  out_hi   = buscfg_reg[31:24];
  wire [7:0]  out_span = (out_hi >= out_lo) ? out_hi - out_lo : 8'h00;
  wire [31:0] bus_mask = (out_span >= 8'h1f) ? 32'hffffffff
                         : ((32'h00000002 << out_span[4:0]) - 32'h00000001);
  wire [31:0] bus_val  = (src_next == DIOH_SRC_LINE) ? line_reg :
                         (src_next == DIOH_SRC_OVRD) ? ovrd_reg :
                         (src_next == DIOH_SRC_ERRN) ? errn_reg : DIOH_ZERO;

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PRDATA_OUT  <= DIOH_ZERO;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
      PSLVERR_OUT <= PSEL_IN & ~PENABLE_IN & ~mapped;
      PRDATA_OUT  <= (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) ? rd_val : DIOH_ZERO;
    end
  end

  // write when pready is high so effect lands at the sampling edge
  wire wr_take = wr & PREADY_OUT;

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      line_reg    <= DIOH_ZERO;
      ovrd_reg    <= DIOH_ZERO;
      errn_reg    <= DIOH_ZERO;
      gpo_reg     <= DIOH_ZERO;
      wear_reg    <= '0;
      zone_en_reg <= '0;
      buscfg_reg  <= DIOH_BUSCFG_RST;
    end else begin
      if (wr_take & hit_line) line_reg <= PWDATA_IN;
      if (wr_take & hit_ovrd) ovrd_reg <= PWDATA_IN;
      if (wr_take & hit_errn) errn_reg <= PWDATA_IN;
      if (wr_take & hit_gpo) gpo_reg <= PWDATA_IN;
      if (wr_take & hit_wear) wear_reg <= PWDATA_IN[NMECH-1:0];
      if (wr_take & hit_zone) zone_en_reg <= PWDATA_IN[NZONES-1:0];
      if (wr_take & hit_bcfg) buscfg_reg <= PWDATA_IN;
    end
  end

  wire jog_clr_take = jog_clr & PREADY_OUT;

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      req_prev_reg    <= 3'h0;
      permit_prev_reg <= 1'b0;
      permit_reg      <= 1'b0;
      src_reg         <= DIOH_SRC_NONE;
    end else begin
      req_prev_reg    <= req_now;
      permit_prev_reg <= MANUAL_MOVE_PERMIT_IN;
      src_reg         <= src_next;
      // a new edge beats a software clear in the same cycle
      if (permit_rise) begin
        permit_reg <= 1'b1;
      end else if (jog_clr_take) begin
        permit_reg <= 1'b0;
      end
    end
  end

  wire permit_next = permit_rise | (permit_reg & ~jog_clr_take);

  always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      NUMERIC_VALUE_BUS_OUT  <= DIOH_ZERO;
      LINE_NUMBER_REPORT_OUT <= 1'b0;
      SPEED_SCALE_REPORT_OUT <= 1'b0;
      FAULT_CODE_REPORT_OUT  <= 1'b0;
      MANUAL_MOVE_PERMIT_OUT <= 1'b0;
      MANUAL_MOVE_STYLE_OUT  <= 2'h0;
      JOG_MOVE_OUT           <= '0;
    end else begin
      NUMERIC_VALUE_BUS_OUT  <= bus_val & bus_mask;
      LINE_NUMBER_REPORT_OUT <= src_next == DIOH_SRC_LINE;
      SPEED_SCALE_REPORT_OUT <= src_next == DIOH_SRC_OVRD;
      FAULT_CODE_REPORT_OUT  <= src_next == DIOH_SRC_ERRN;
      MANUAL_MOVE_PERMIT_OUT <= permit_next;
      MANUAL_MOVE_STYLE_OUT  <= MANUAL_MOVE_STYLE_IN;
      // both directions at once is contradictory, so neither moves
      JOG_MOVE_OUT.pos <= permit_next ? JOG_REQ_IN.pos & ~JOG_REQ_IN.neg : '0;
      JOG_MOVE_OUT.neg <= permit_next ? JOG_REQ_IN.neg & ~JOG_REQ_IN.pos : '0;
    end
  end

  // per-mechanism mirrors and faults
  for (genvar m = 0; m < NMECH; m++) begin : g_mech
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        GRIPPER_OUTPUT_MIRROR_OUT[m*8 +: 8] <= 8'h00;
        GRIPPER_INPUT_MIRROR_OUT[m*8 +: 8]  <= 8'h00;
        GRIPPER_FAULT_OUT[m]                <= 1'b0;
        AIR_PRESSURE_FAULT_OUT[m]           <= 1'b0;
        PARTS_WEAR_WARNING_OUT[m]           <= 1'b0;
      end else begin
        GRIPPER_OUTPUT_MIRROR_OUT[m*8 +: 8] <= gpo_reg[m*8 +: 8];
        GRIPPER_INPUT_MIRROR_OUT[m*8 +: 8]  <= GRIPPER_INPUTS_IN[m*8 +: 8];
        GRIPPER_FAULT_OUT[m]                <= GRIPPER_FAULT_IN[m];
        AIR_PRESSURE_FAULT_OUT[m]           <= AIR_PRESSURE_FAULT_IN[m];
        PARTS_WEAR_WARNING_OUT[m]           <= wear_reg[m];
      end
    end
  end

  for (genvar z = 0; z < NZONES; z++) begin : g_zone
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
        ZONE_OCCUPANCY_OUT[z] <= 1'b0;
      end else begin
        ZONE_OCCUPANCY_OUT[z] <= zone_en_reg[z] & ROBOT_IN_ZONE_IN[z];
      end
    end
  end

  // checks
  sequence s_line_edge;
    !LINE_NUMBER_REPORT_REQUEST_IN ##1 LINE_NUMBER_REPORT_REQUEST_IN;
  endsequence

  property p_line_report;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      s_line_edge |=> LINE_NUMBER_REPORT_OUT;
  endproperty
  a_line_report: assert property (p_line_report) else $error("line report missed");

  property p_line_bus;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (s_line_edge ##1 ($stable(buscfg_reg) && $stable(line_reg)))
      |-> NUMERIC_VALUE_BUS_OUT == (line_reg & bus_mask);
  endproperty
  a_line_bus: assert property (p_line_bus) else $error("bus lacks line number");

  property p_ovrd_report;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      ($rose(SPEED_SCALE_REPORT_REQUEST_IN) && !req_rise[0]) |=> SPEED_SCALE_REPORT_OUT;
  endproperty
  a_ovrd_report: assert property (p_ovrd_report) else $error("override report missed");

  property p_onehot;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      $onehot0({LINE_NUMBER_REPORT_OUT, SPEED_SCALE_REPORT_OUT, FAULT_CODE_REPORT_OUT});
  endproperty
  a_onehot: assert property (p_onehot) else $error("two indicators high");

  property p_report_holds;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (FAULT_CODE_REPORT_OUT && req_rise == 3'h0) |=> FAULT_CODE_REPORT_OUT;
  endproperty
  a_report_holds: assert property (p_report_holds) else $error("report dropped");

  property p_permit;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      $rose(MANUAL_MOVE_PERMIT_IN) |=> MANUAL_MOVE_PERMIT_OUT [*2] or
        (MANUAL_MOVE_PERMIT_OUT ##1 $past(jog_clr_take));
  endproperty
  a_permit: assert property (p_permit) else $error("permit not held");

  property p_jog_level;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !JOG_REQ_IN.pos[0] |=> !JOG_MOVE_OUT.pos[0];
  endproperty
  a_jog_level: assert property (p_jog_level) else $error("jog moved unheld");

  property p_style;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      1'b1 |=> MANUAL_MOVE_STYLE_OUT == $past(MANUAL_MOVE_STYLE_IN);
  endproperty
  a_style: assert property (p_style) else $error("style not reported");

  property p_grip_fault;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      GRIPPER_FAULT_IN[0] [*2] |=> GRIPPER_FAULT_OUT[0] && $past(GRIPPER_FAULT_OUT[0]);
  endproperty
  a_grip_fault: assert property (p_grip_fault) else $error("gripper fault lost");

  property p_air_fault;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      $fell(AIR_PRESSURE_FAULT_IN[0]) |=> !AIR_PRESSURE_FAULT_OUT[0];
  endproperty
  a_air_fault: assert property (p_air_fault) else $error("air fault stuck");

  property p_err_report;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      ($rose(FAULT_CODE_REPORT_REQUEST_IN) && req_rise[1:0] == 2'h0) |=> FAULT_CODE_REPORT_OUT;
  endproperty
  a_err_report: assert property (p_err_report) else $error("error report missed");

  property p_line_holds;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (LINE_NUMBER_REPORT_OUT && req_rise == 3'h0) |=> LINE_NUMBER_REPORT_OUT;
  endproperty
  a_line_holds: assert property (p_line_holds) else $error("line report dropped");

  property p_ovrd_holds;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (SPEED_SCALE_REPORT_OUT && req_rise == 3'h0) |=> SPEED_SCALE_REPORT_OUT;
  endproperty
  a_ovrd_holds: assert property (p_ovrd_holds) else $error("override report dropped");

  property p_jog_neg;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !JOG_REQ_IN.neg[0] |=> !JOG_MOVE_OUT.neg[0];
  endproperty
  a_jog_neg: assert property (p_jog_neg) else $error("minus jog moved unheld");

  property p_jog_gate;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !MANUAL_MOVE_PERMIT_OUT |-> {JOG_MOVE_OUT.pos, JOG_MOVE_OUT.neg} == '0;
  endproperty
  a_jog_gate: assert property (p_jog_gate) else $error("jog moved without permit");

  property p_permit_clear;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      (jog_clr_take && !permit_rise) |=> !MANUAL_MOVE_PERMIT_OUT;
  endproperty
  a_permit_clear: assert property (p_permit_clear) else $error("permit not cleared");

  // mechanism one stands for all three output mirror groups
  wire [7:0] grip0_cmd = gpo_reg[7:0];

  property p_gpo_mirror;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      1'b1 |=> GRIPPER_OUTPUT_MIRROR_OUT[7:0] == $past(grip0_cmd);
  endproperty
  a_gpo_mirror: assert property (p_gpo_mirror) else $error("output mirror wrong");

  property p_gin_mirror;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      1'b1 |=> GRIPPER_INPUT_MIRROR_OUT == $past(GRIPPER_INPUTS_IN);
  endproperty
  a_gin_mirror: assert property (p_gin_mirror) else $error("input mirror wrong");

  property p_wear;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      1'b1 |=> PARTS_WEAR_WARNING_OUT == $past(wear_reg);
  endproperty
  a_wear: assert property (p_wear) else $error("wear warning wrong");

  property p_zone;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !ROBOT_IN_ZONE_IN[0] |=> !ZONE_OCCUPANCY_OUT[0];
  endproperty
  a_zone: assert property (p_zone) else $error("zone high while outside");

  property p_air_set;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      AIR_PRESSURE_FAULT_IN[0] |=> AIR_PRESSURE_FAULT_OUT[0];
  endproperty
  a_air_set: assert property (p_air_set) else $error("air fault missed");

  property p_grip_clear;
    @(posedge CORE_CLK_IN) disable iff (RESET_IN)
      !GRIPPER_FAULT_IN[0] |=> !GRIPPER_FAULT_OUT[0];
  endproperty
  a_grip_clear: assert property (p_grip_clear) else $error("gripper fault stuck");
endmodule

// ==== src/dioh_pkg.sv ====
// package for the dedicated i/o signal handler: register map, fields, resets.
// assumes a 32-bit apb slave with word-aligned registers.
package dioh_pkg;
  localparam int          DIOH_NAXES       = 8;
  localparam int          DIOH_NMECH       = 3;
  localparam int          DIOH_NZONES      = 8;
  localparam logic [11:0] DIOH_CTRL_OFF    = 12'h000;
  localparam logic [11:0] DIOH_LINE_OFF    = 12'h004;
  localparam logic [11:0] DIOH_OVRD_OFF    = 12'h008;
  localparam logic [11:0] DIOH_ERRN_OFF    = 12'h00c;
  localparam logic [11:0] DIOH_GPO_OFF     = 12'h010;
  localparam logic [11:0] DIOH_WEAR_OFF    = 12'h014;
  localparam logic [11:0] DIOH_ZONE_OFF    = 12'h018;
  localparam logic [11:0] DIOH_BUSCFG_OFF  = 12'h01c;
  localparam logic [11:0] DIOH_STAT_OFF    = 12'h020;
  localparam int          DIOH_CTRL_JOGCLR = 0;
  localparam logic [31:0] DIOH_BUSCFG_RST  = 32'h0f000f00;
  localparam logic [31:0] DIOH_ZERO        = 32'h00000000;

  typedef enum logic [1:0] {
    DIOH_SRC_NONE,
    DIOH_SRC_LINE,
    DIOH_SRC_OVRD,
    DIOH_SRC_ERRN
  } dioh_src_e;

  typedef struct packed {
    logic [DIOH_NAXES-1:0] pos;
    logic [DIOH_NAXES-1:0] neg;
  } dioh_jog_s;
endpackage

// ==== tb/dioh_ctrl_model.sv ====
// external controller model: drives every parallel input of the handler.
// assumes the bench calls its tasks; changes land just after a rising edge.
`timescale 1ns/1ns
module dioh_ctrl_model (
  input  wire logic           clk_in,
  output logic      [3:0]     edge_req_out,
  output logic      [1:0]     style_out,
  output dioh_pkg::dioh_jog_s jog_out,
  output logic      [23:0]    grip_in_out,
  output logic      [2:0]     grip_flt_out,
  output logic      [2:0]     air_flt_out,
  output logic      [7:0]     zone_out
);
  import dioh_pkg::*;
  initial begin
    edge_req_out = 4'h0;
    style_out    = 2'h0;
    jog_out      = '0;
    grip_in_out  = 24'h0;
    grip_flt_out = 3'h0;
    air_flt_out  = 3'h0;
    zone_out     = 8'h0;
  end
  // edge inputs: held two cycles, then low two so the next call fires again
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_in);
    edge_req_out <= m;
    repeat (2) @(posedge clk_in);
    edge_req_out <= 4'h0;
    repeat (2) @(posedge clk_in);
  endtask
  // level inputs stay steady until the next call
  task automatic lv(input logic [1:0] s, input dioh_jog_s j, input logic [23:0] g,
                    input logic [2:0] f, input logic [2:0] a, input logic [7:0] z);
    @(posedge clk_in);
    style_out    <= s;
    jog_out      <= j;
    grip_in_out  <= g;
    grip_flt_out <= f;
    air_flt_out  <= a;
    zone_out     <= z;
  endtask
endmodule

// ==== tb/test_dedicated_io_signal_handler.sv ====
// bench for the dedicated i/o handler: apb master, controller model, expectations.
// assumes the handler answers apb with pready; expected values come from the rules.
`timescale 1ns/1ns
module test_dedicated_io_signal_handler;
  import dioh_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] seed = 32'hd27d;
  logic [31:0] q;
  logic [31:0] r [6];
  logic [31:0] val [3];
  logic        e;
  int          n_mismatch = 0;
  int          compares = 0;
  wire  [31:0] prdata, bus;
  wire         pready, pslverr, perm;
  wire  [3:0]  ereq;
  wire  [2:0]  ind, gflt, aflt, gf_m, af_m, wear_m;
  wire  [1:0]  style, style_q;
  wire  [23:0] gin, gpo_m, gin_m;
  wire  [7:0]  zin, zone_m;
  wire dioh_jog_s jog, move;
  localparam logic [11:0] REP_OFF [3] = '{DIOH_LINE_OFF, DIOH_OVRD_OFF, DIOH_ERRN_OFF};

  always #20 clk = ~clk;

  dioh_ctrl_model u_ctl (.clk_in(clk), .edge_req_out(ereq), .style_out(style), .jog_out(jog),
    .grip_in_out(gin), .grip_flt_out(gflt), .air_flt_out(aflt), .zone_out(zin));

  dioh_handler u_dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINE_NUMBER_REPORT_REQUEST_IN(ereq[0]),
    .SPEED_SCALE_REPORT_REQUEST_IN(ereq[1]), .FAULT_CODE_REPORT_REQUEST_IN(ereq[2]),
    .MANUAL_MOVE_PERMIT_IN(ereq[3]), .MANUAL_MOVE_STYLE_IN(style), .JOG_REQ_IN(jog),
    .GRIPPER_INPUTS_IN(gin), .GRIPPER_FAULT_IN(gflt), .AIR_PRESSURE_FAULT_IN(aflt),
    .ROBOT_IN_ZONE_IN(zin), .NUMERIC_VALUE_BUS_OUT(bus), .LINE_NUMBER_REPORT_OUT(ind[0]),
    .SPEED_SCALE_REPORT_OUT(ind[1]), .FAULT_CODE_REPORT_OUT(ind[2]),
    .MANUAL_MOVE_PERMIT_OUT(perm), .MANUAL_MOVE_STYLE_OUT(style_q), .JOG_MOVE_OUT(move),
    .GRIPPER_OUTPUT_MIRROR_OUT(gpo_m), .GRIPPER_INPUT_MIRROR_OUT(gin_m),
    .GRIPPER_FAULT_OUT(gf_m), .AIR_PRESSURE_FAULT_OUT(af_m),
    .PARTS_WEAR_WARNING_OUT(wear_m), .ZONE_OCCUPANCY_OUT(zone_m));

  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic rnd(output logic [31:0] v);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v = seed;
  endtask

  // request held until pready is seen high; bounded so a dead slave ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      results();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(bus, DIOH_ZERO);
    chk({29'h0, ind}, DIOH_ZERO);
    apb(1'b0, DIOH_BUSCFG_OFF, DIOH_ZERO, q, e);
    chk(q, DIOH_BUSCFG_RST);
    apb(1'b0, 12'h0fc, DIOH_ZERO, q, e);
    chk(q, DIOH_ZERO);
    chk({31'h0, e}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      rnd(val[k]);
      apb(1'b1, REP_OFF[k], val[k], q, e);
    end
    for (int k = 0; k < 3; k++) begin
      u_ctl.pulse(4'h1 << k);
      @(negedge clk);
      chk(bus, val[k] & 32'hffff);
      chk({29'h0, ind}, 32'h1 << k);
    end
    // override and fault rise together: only one source may win
    u_ctl.pulse(4'h6);
    @(negedge clk);
    chk({29'h0, ind}, 32'h2);
    chk(bus, val[1] & 32'hffff);
    apb(1'b1, DIOH_BUSCFG_OFF, 32'h0b040300, q, e);
    apb(1'b0, DIOH_BUSCFG_OFF, DIOH_ZERO, q, e);
    chk(q, 32'h0b040300);
    u_ctl.pulse(4'h1);
    @(negedge clk);
    chk(bus, val[0] & 32'hff);
    // last pass drops every level to prove outputs follow them down
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 6; k++) begin
        rnd(r[k]);
        if (i == 4) r[k] = 32'h0;
      end
      if (i == 1) u_ctl.pulse(4'h8);
      apb(1'b1, DIOH_GPO_OFF, r[0], q, e);
      apb(1'b1, DIOH_WEAR_OFF, r[1], q, e);
      apb(1'b1, DIOH_ZONE_OFF, r[2], q, e);
      u_ctl.lv(r[3][1:0], r[3][31:16], r[4][23:0], r[4][26:24], r[4][29:27], r[5][7:0]);
      repeat (2) @(negedge clk);
      chk({31'h0, perm}, {31'h0, i > 0});
      chk({30'h0, style_q}, {30'h0, r[3][1:0]});
      chk({16'h0, move}, (i > 0) ? {16'h0, r[3][31:24] & ~r[3][23:16],
                                    r[3][23:16] & ~r[3][31:24]} : 32'h0);
      chk({8'h0, gpo_m}, {8'h0, r[0][23:0]});
      chk({8'h0, gin_m}, {8'h0, r[4][23:0]});
      chk({26'h0, af_m, gf_m}, {26'h0, r[4][29:24]});
      chk({29'h0, wear_m}, {29'h0, r[1][2:0]});
      chk({24'h0, zone_m}, {24'h0, r[2][7:0] & r[5][7:0]});
    end
    apb(1'b1, DIOH_CTRL_OFF, 32'h1, q, e);
    repeat (2) @(negedge clk);
    chk({31'h0, perm}, DIOH_ZERO);
    // status: line source, style zero, permit cleared
    apb(1'b0, DIOH_STAT_OFF, DIOH_ZERO, q, e);
    chk(q, 32'h1);
    results();
  end
endmodule
